// File: pkg/spims_pkg.sv
/*
   Package of the SPI master/slave port: register offsets, control and status bit positions,
   reset values and the SCK divisor table that the rate divider halves into half periods.
   Assumes an 8-bit register file reached over a plain strobe port with a 2-bit address.
*/
package spims_pkg;

   // Register bus geometry.
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 8;

   // Register offsets.
   localparam logic [1:0] OFS_SPI_CONTROL      = 2'h0;
   localparam logic [1:0] OFS_IRQ_LEVEL_CONFIG = 2'h1;
   localparam logic [1:0] OFS_TRANSFER_STATUS  = 2'h2;
   localparam logic [1:0] OFS_SHIFT_DATA       = 2'h3;

   // Control register fields.
   localparam int unsigned CTL_DOUBLE_RATE_BIT = 7;
   localparam int unsigned CTL_ENABLE_BIT      = 6;
   localparam int unsigned CTL_LSB_FIRST_BIT   = 5;
   localparam int unsigned CTL_MASTER_BIT      = 4;
   localparam int unsigned CTL_MODE_MSB        = 3;
   localparam int unsigned CTL_MODE_LSB        = 2;
   localparam int unsigned CTL_PRESC_MSB       = 1;
   localparam int unsigned CTL_PRESC_LSB       = 0;

   // Interrupt level field.
   localparam int unsigned IRQ_LVL_MSB = 1;
   localparam int unsigned IRQ_LVL_LSB = 0;

   // Status register fields.
   localparam int unsigned STS_XFER_DONE_BIT = 7;
   localparam int unsigned STS_WCOL_BIT      = 6;

   // Reset values.
   localparam logic [7:0] RST_SPI_CONTROL = 8'h00;
   localparam logic [1:0] RST_IRQ_LEVEL   = 2'h0;
   localparam logic [7:0] RST_SHIFT_DATA  = 8'h00;

   // Word offset of the single interrupt vector of the port.
   localparam logic [7:0] IRQ_VECTOR_OFFSET = 8'h00;

   // Index of the last bit and of the last SCK edge of a transfer.
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hF;

   // SCK divisors of the peripheral clock; a half period is half the divisor.
   localparam int unsigned DIV_N0 = 4;
   localparam int unsigned DIV_N1 = 16;
   localparam int unsigned DIV_N2 = 64;
   localparam int unsigned DIV_N3 = 128;
   localparam int unsigned DIV_D0 = 2;
   localparam int unsigned DIV_D1 = 8;
   localparam int unsigned DIV_D2 = 32;
   localparam int unsigned DIV_D3 = 64;
   localparam int unsigned HALF_CNT_W = 7;

endpackage

// File: pkg/spims_rate_if.sv
/*
   Interface between the port core and its SCK rate divider.
   Assumes both ends run on the same peripheral clock.
*/
`timescale 1ns/1ps
interface spims_rate_if;
   logic       run;
   logic       double_rate_select;
   logic [1:0] prescale;
   logic       half_tick;

   modport ctl (output run, output double_rate_select, output prescale, input half_tick);
   modport gen (input run, input double_rate_select, input prescale, output half_tick);
endinterface

// File: tb/spims_assertions.sv
/*
   Checker of the SPI port, bound to the top module and watching its ports only.
   Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module spims_assertions (
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Interrupt and DMA
   input wire logic       irq_ack,
   input wire logic       irq_req,
   input wire logic [1:0] irq_priority_level,
   input wire logic [7:0] irq_vector_offset,
   input wire logic       dma_req,
   // Serial pins
   input wire logic       ss_n_in,
   input wire logic       ss_is_input,
   input wire logic       sck_in,
   input wire logic       sck_out,
   input wire logic       sck_oe,
   input wire logic       mosi_in,
   input wire logic       mosi_out,
   input wire logic       mosi_oe,
   input wire logic       miso_in,
   input wire logic       miso_out,
   input wire logic       miso_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   AST_STS_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 2'h2 |-> reg_rdata[5:0] == 6'h00)
      else $error("status low bits not zero");
   AST_IRQ_LVL: assert property (irq_req |-> irq_priority_level != 2'h0)
      else $error("interrupt raised at level zero");
   AST_VEC: assert property (irq_vector_offset == 8'h00)
      else $error("vector offset not zero");
   AST_DMA_SLV: assert property (dma_req |-> !sck_oe && !mosi_oe)
      else $error("dma request outside slave mode");
   AST_DMA_PULSE: assert property (dma_req |=> !dma_req)
      else $error("dma request longer than one cycle");
   AST_ROLE_PINS: assert property (sck_oe == mosi_oe && !(sck_oe && miso_oe))
      else $error("master and slave drivers mixed");
   AST_DESEL_FLOAT: assert property (miso_oe |-> $past(ss_n_in, 2) == 1'b0)
      else $error("miso driven while deselected");
   AST_FAULT: assert property (sck_oe && ss_is_input && !ss_n_in |-> ##[1:4] !sck_oe)
      else $error("master kept after select fault");
   AST_ACK: assert property (irq_req && irq_ack |=> !irq_req)
      else $error("interrupt kept after acknowledge");
endmodule

// File: tb/spims_partner.sv
/*
   Behavioural SPI slave standing on the far side of the port in master mode.
   Assumes the frame format is given by the bench and select frames each byte.
*/
`timescale 1ns/1ps
module spims_partner (
   // Serial pins
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   output logic            miso,
   // Format and data
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsb_first,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte
);
   int idx = 0;

   function automatic logic pick(input int i);
      return lsb_first ? tx_byte[i] : tx_byte[7-i];
   endfunction

   initial begin
      miso    = 1'b0;
      rx_byte = 8'h00;
   end
   // A released line shows the inverse of its last level, so stale data is never taken as good.
   always @(posedge ss_n) miso = ~miso;
   always @(negedge ss_n) begin
      idx = cpha ? 0 : 1;
      if (!cpha) miso = pick(0);
   end
   always @(sck) begin
      if (!ss_n && ((sck != cpol) ^ cpha)) begin
         rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      end else if (!ss_n && idx < 8) begin
         miso = pick(idx);
         idx++;
      end
   end
endmodule

// File: tb/tb.sv
/*
   Self-checking bench of the SPI port: registers, master rates and formats, flags and slave mode.
   Assumes the partner model as far-side slave; the bench itself acts as far-side master.
*/
`timescale 1ns/1ps
module tb;
   import spims_pkg::*;
   logic       clk, reset, reg_wr, reg_rd, irq_ack, ss_n_in, ss_is_input, tb_sck, tb_mosi;
   logic       irq_req, dma_req, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, p_miso;
   logic       sck_prev = 1'b0;
   logic [1:0] reg_addr, irq_priority_level;
   logic [7:0] reg_wdata, reg_rdata, irq_vector_offset, p_tx, p_rx, ctl;
   wire        sck_in  = sck_oe ? sck_out : tb_sck;
   wire        mosi_in = mosi_oe ? mosi_out : tb_mosi;
   wire        miso_in = miso_oe ? miso_out : p_miso;
   int         n_fail, cmp_count, n_edge, n_dma;
   time        t0, t1;

   spims_top spims_top_i (.*);
   spims_partner spims_partner_i (.sck(sck_in), .mosi(mosi_in), .ss_n(ss_n_in), .miso(p_miso),
      .cpol(ctl[3]), .cpha(ctl[2]), .lsb_first(ctl[5]), .tx_byte(p_tx), .rx_byte(p_rx));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Edges are seen one cycle late, equally for all, so spacing stays exact.
   always @(posedge clk) begin
      sck_prev <= sck_out;
      if (sck_out !== sck_prev) begin
         if (n_edge == 0) t0 = $time;
         t1 = $time;
         n_edge++;
      end
      if (dma_req === 1'b1) n_dma++;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkn(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   task automatic wait_edges(input int n);
      for (int k = 0; k < 5000 && n_edge < n; k++) @(posedge clk);
      if (n_edge < n) begin
         n_fail++;
         conclude();
      end
   endtask

   task automatic regs_reset();
      logic [7:0] d;
      rd(OFS_SPI_CONTROL, d);
      chk8(d, RST_SPI_CONTROL);
      rd(OFS_IRQ_LEVEL_CONFIG, d);
      chk8(d, {6'h00, RST_IRQ_LEVEL});
      wr(OFS_TRANSFER_STATUS, 8'hFF);
      rd(OFS_TRANSFER_STATUS, d);
      chk8(d, 8'h00);
      wr(OFS_SPI_CONTROL, 8'h10);
      wr(OFS_SHIFT_DATA, 8'h33);
      repeat (40) @(posedge clk);
      chkn(n_edge, 0);
      rd(OFS_TRANSFER_STATUS, d);
      chk8(d, 8'h00);
      chk8(irq_vector_offset, IRQ_VECTOR_OFFSET);
   endtask

   task automatic xfer(input logic [2:0] i);
      logic [7:0] d, tx_m, sts;
      int         dv[8] = '{DIV_N0, DIV_N1, DIV_N2, DIV_N3, DIV_D0, DIV_D1, DIV_D2, DIV_D3};
      tx_m = 8'h1C + {5'h00, i};
      p_tx = 8'hC4 ^ {5'h00, i};
      ctl  = {i[2], 1'b1, i[0] ^ i[2], 1'b1, i[1:0], i[1:0]};
      sts  = {1'b1, i[1:0] == 2'h2, 6'h00};
      wr(OFS_IRQ_LEVEL_CONFIG, {6'h00, i[1:0]});
      wr(OFS_SPI_CONTROL, ctl);
      // A polarity change moves SCK one cycle after the write, so let it settle before select drops.
      repeat (3) @(posedge clk);
      n_edge = 0;
      ss_n_in <= 1'b0;
      wr(OFS_SHIFT_DATA, tx_m);
      if (i[1:0] == 2'h2) begin
         wait_edges(4);
         wr(OFS_SHIFT_DATA, 8'h5A);
      end
      wait_edges(16);
      repeat (4) @(posedge clk);
      ss_n_in <= 1'b1;
      chkn(n_edge, 16);
      chkn(int'(t1 - t0), 15 * dv[i] * 4);
      chk8({7'h00, sck_out}, {7'h00, ctl[3]});
      chk8(p_rx, tx_m);
      chk8({7'h00, irq_req}, {7'h00, i[1:0] != 2'h0});
      chk8({6'h00, irq_priority_level}, {6'h00, i[1:0]});
      if (i[0]) begin
         irq_ack <= 1'b1;
         @(posedge clk);
         irq_ack <= 1'b0;
         sts[7] = 1'b0;
      end
      rd(OFS_TRANSFER_STATUS, d);
      chk8(d, sts);
      rd(OFS_SHIFT_DATA, d);
      chk8(d, p_tx);
      rd(OFS_TRANSFER_STATUS, d);
      chk8(d, 8'h00);
   endtask

   task automatic fault();
      logic [7:0] d;
      wr(OFS_SPI_CONTROL, 8'h50);
      ss_is_input <= 1'b1;
      ss_n_in     <= 1'b0;
      repeat (6) @(posedge clk);
      rd(OFS_SPI_CONTROL, d);
      chk8(d, 8'h40);
      rd(OFS_TRANSFER_STATUS, d);
      chk8(d, 8'h80);
      rd(OFS_SHIFT_DATA, d);
      @(posedge clk);
      ss_n_in     <= 1'b1;
      ss_is_input <= 1'b0;
   endtask

   task automatic sbyte(input int nb, input logic [7:0] m, output logic [7:0] s);
      ss_n_in <= 1'b0;
      repeat (4) @(posedge clk);
      chk8({7'h00, miso_oe}, 8'h01);
      for (int b = 7; b > 7 - nb; b--) begin
         tb_mosi <= m[b];
         repeat (4) @(posedge clk);
         tb_sck <= 1'b1;
         s[b] = miso_in;
         repeat (4) @(posedge clk);
         tb_sck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      ss_n_in <= 1'b1;
      repeat (4) @(posedge clk);
      chk8({7'h00, miso_oe}, 8'h00);
   endtask

   task automatic slave();
      logic [7:0] d, s;
      wr(OFS_SPI_CONTROL, 8'h43);
      wr(OFS_SHIFT_DATA, 8'h96);
      n_dma = 0;
      sbyte(8, 8'h3A, s);
      chk8(s, 8'h96);
      chkn(n_dma, 1);
      rd(OFS_TRANSFER_STATUS, d);
      chk8(d, 8'h80);
      rd(OFS_SHIFT_DATA, d);
      chk8(d, 8'h3A);
      sbyte(3, 8'hFF, s);
      sbyte(8, 8'h65, s);
      chkn(n_dma, 2);
      rd(OFS_SHIFT_DATA, d);
      chk8(d, 8'h65);
   endtask

   initial begin
      reset       = 1'b1;
      reg_addr    = 2'h0;
      reg_wdata   = 8'h00;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      irq_ack     = 1'b0;
      ss_n_in     = 1'b1;
      ss_is_input = 1'b0;
      tb_sck      = 1'b0;
      tb_mosi     = 1'b0;
      ctl         = 8'h00;
      p_tx        = 8'h00;
      n_fail      = 0;
      cmp_count   = 0;
      n_edge      = 0;
      n_dma       = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      regs_reset();
      for (int i = 0; i < 8; i++) xfer(3'(i));
      fault();
      slave();
      conclude();
   end
endmodule

bind spims_top spims_assertions spims_assertions_i (.*);

// File: verilog/spims_clkdiv.sv
/*
   SCK rate divider: emits a one-cycle half_tick every half SCK period while run is high.
   Assumes run is dropped between transfers so that each transfer starts with a full half period.
*/
`timescale 1ns/1ps
module spims_clkdiv (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Rate control
   spims_rate_if.gen rate
);
   import spims_pkg::*;

   logic [HALF_CNT_W-1:0] cnt_r;
   logic [HALF_CNT_W-1:0] limit;

   // Half-period lengths in peripheral clocks, less one.
   always_comb begin
      unique case ({rate.double_rate_select, rate.prescale})
         3'b000: limit = HALF_CNT_W'(DIV_N0 / 2 - 1);
         3'b001: limit = HALF_CNT_W'(DIV_N1 / 2 - 1);
         3'b010: limit = HALF_CNT_W'(DIV_N2 / 2 - 1);
         3'b011: limit = HALF_CNT_W'(DIV_N3 / 2 - 1);
         3'b100: limit = HALF_CNT_W'(DIV_D0 / 2 - 1);
         3'b101: limit = HALF_CNT_W'(DIV_D1 / 2 - 1);
         3'b110: limit = HALF_CNT_W'(DIV_D2 / 2 - 1);
         3'b111: limit = HALF_CNT_W'(DIV_D3 / 2 - 1);
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset || !rate.run || cnt_r == limit) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign rate.half_tick = rate.run && (cnt_r == limit);
endmodule

// File: verilog/spims_sync.sv
/*
   Two-flop synchroniser, one chain per bit.
   Assumes the inputs are levels that stay stable for more than two clock periods.
*/
`timescale 1ns/1ps
module spims_sync #(
   parameter int unsigned WIDTH = 3
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_r;
         always_ff @(posedge clk) begin
            if (reset) begin
               meta_r <= 1'b1;
               q[i]   <= 1'b1;
            end else begin
               meta_r <= d[i];
               q[i]   <= meta_r;
            end
         end
      end
   endgenerate
endmodule

// File: verilog/spims_top.sv
/*
   SPI master/slave port with four byte registers, one interrupt request and a slave DMA request.
   Assumes a plain register port with read data one cycle after the read strobe, and an outside
   pin driver that combines the *_out/*_oe pairs into the real SCK, MOSI and MISO wires.
*/
`timescale 1ns/1ps
module spims_top (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // Register port
   input  wire logic [spims_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [spims_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [spims_pkg::DATA_W-1:0] reg_rdata,
   // Interrupt and DMA
   input  wire logic                        irq_ack,
   output logic                             irq_req,
   output logic      [1:0]                  irq_priority_level,
   output logic      [7:0]                  irq_vector_offset,
   output logic                             dma_req,
   // Slave select pin
   input  wire logic                        ss_n_in,
   input  wire logic                        ss_is_input,
   // SCK pin
   input  wire logic                        sck_in,
   output logic                             sck_out,
   output logic                             sck_oe,
   // MOSI pin
   input  wire logic                        mosi_in,
   output logic                             mosi_out,
   output logic                             mosi_oe,
   // MISO pin
   input  wire logic                        miso_in,
   output logic                             miso_out,
   output logic                             miso_oe
);
   import spims_pkg::*;

   logic [7:0] ctrl_r;
   logic [1:0] irq_lvl_r;
   logic       xfer_done_flag_r;
   logic       write_collision_flag_r;
   logic       done_arm_r;
   logic       wcol_arm_r;
   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;
   logic [7:0] rx_buf_r;
   logic [2:0] bit_cnt_r;
   logic       m_run_r;
   logic [3:0] edge_cnt_r;
   logic       sck_r;
   logic       sck_d_r;
   logic       dma_req_r;
   logic [2:0] sync_q;
   logic       sck_s;
   logic       ss_s;
   logic       mosi_s;

   logic       enable;
   logic       is_master;
   logic       lsb_first_select;
   logic       cpha;
   logic       cpol;
   logic       data_wr;
   logic       data_acc;
   logic       sts_rd;
   logic       mode_fault;
   logic       m_edge;
   logic       s_edge;
   logic       edge_any;
   logic       edge_leading;
   logic       sample;
   logic       setup;
   logic       in_bit;
   logic       tx_bit;
   logic       byte_done;
   logic       m_done;
   logic       xfer_done;
   logic       busy;
   logic       start;

   spims_rate_if rate ();

   spims_clkdiv u_clkdiv (
      .clk   (clk),
      .reset (reset),
      .rate  (rate.gen)
   );

   // SCK, select and MOSI come from the far master, so they cross into our clock before use.
   spims_sync #(.WIDTH(3)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({mosi_in, ss_n_in, sck_in}),
      .q     (sync_q)
   );

   assign sck_s  = sync_q[0];
   assign ss_s   = sync_q[1];
   assign mosi_s = sync_q[2];

   assign enable           = ctrl_r[CTL_ENABLE_BIT];
   assign is_master        = ctrl_r[CTL_MASTER_BIT];
   assign lsb_first_select = ctrl_r[CTL_LSB_FIRST_BIT];
   assign cpha             = ctrl_r[CTL_MODE_LSB];
   assign cpol             = ctrl_r[CTL_MODE_MSB];

   assign data_wr  = reg_wr && (reg_addr == OFS_SHIFT_DATA);
   assign data_acc = (reg_wr || reg_rd) && (reg_addr == OFS_SHIFT_DATA);
   assign sts_rd   = reg_rd && (reg_addr == OFS_TRANSFER_STATUS);

   // Another master pulling select low while we drive the bus.
   assign mode_fault = enable && is_master && ss_is_input && !ss_s;

   // The divider only runs for a master transfer, so the rate field cannot touch slave timing.
   assign rate.run                = m_run_r && is_master && enable;
   assign rate.double_rate_select = ctrl_r[CTL_DOUBLE_RATE_BIT];
   assign rate.prescale           = ctrl_r[CTL_PRESC_MSB:CTL_PRESC_LSB];

   assign m_edge = rate.half_tick;
   assign s_edge = enable && !is_master && !ss_s && (sck_s != sck_d_r);

   assign edge_any     = m_edge || s_edge;
   assign edge_leading = is_master ? !edge_cnt_r[0] : (sck_s != cpol);
   assign sample       = edge_any && (edge_leading != cpha);
   assign setup        = edge_any && (edge_leading == cpha);

   assign in_bit    = is_master ? miso_in : mosi_s;
   assign tx_bit    = lsb_first_select ? tx_sh_r[0] : tx_sh_r[7];
   assign byte_done = sample && (bit_cnt_r == LAST_BIT);
   assign m_done    = m_edge && (edge_cnt_r == LAST_EDGE);
   assign xfer_done = is_master ? m_done : byte_done;
   assign busy      = is_master ? m_run_r : (!ss_s && bit_cnt_r != 3'h0);
   assign start     = data_wr && enable && is_master && !m_run_r && !mode_fault;

   // Control register; a mode fault clears the role bit even against a same-cycle write.
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r <= RST_SPI_CONTROL;
      end else begin
         if (reg_wr && reg_addr == OFS_SPI_CONTROL) begin
            ctrl_r <= reg_wdata;
         end
         if (mode_fault) begin
            ctrl_r[CTL_MASTER_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_lvl_r <= RST_IRQ_LEVEL;
      end else if (reg_wr && reg_addr == OFS_IRQ_LEVEL_CONFIG) begin
         irq_lvl_r <= reg_wdata[IRQ_LVL_MSB:IRQ_LVL_LSB];
      end
   end

   // Master clock generator: sixteen half periods, then SCK returns to its idle level.
   always_ff @(posedge clk) begin
      if (reset) begin
         m_run_r    <= 1'b0;
         edge_cnt_r <= 4'h0;
      end else if (!enable || !is_master || mode_fault) begin
         m_run_r    <= 1'b0;
         edge_cnt_r <= 4'h0;
      end else if (start) begin
         m_run_r    <= 1'b1;
         edge_cnt_r <= 4'h0;
      end else if (m_edge) begin
         m_run_r    <= (edge_cnt_r != LAST_EDGE);
         edge_cnt_r <= edge_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sck_r <= 1'b0;
      end else if (!m_run_r) begin
         sck_r <= cpol;
      end else if (m_edge) begin
         sck_r <= !sck_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sck_d_r <= 1'b0;
      end else begin
         sck_d_r <= sck_s;
      end
   end

   // Bit counter; a deselect throws away a partial slave byte.
   always_ff @(posedge clk) begin
      if (reset) begin
         bit_cnt_r <= 3'h0;
      end else if (!enable || start || (!is_master && ss_s)) begin
         bit_cnt_r <= 3'h0;
      end else if (sample) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   // Transmit shift register. The first setup edge of a phase-one frame only presents the
   // first bit, so shifting waits until at least one bit has been sampled.
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_sh_r <= RST_SHIFT_DATA;
      end else if (data_wr && !busy) begin
         tx_sh_r <= reg_wdata;
      end else if (setup && bit_cnt_r != 3'h0) begin
         if (lsb_first_select) begin
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
         end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_sh_r <= 8'h00;
      end else if (sample) begin
         if (lsb_first_select) begin
            rx_sh_r <= {in_bit, rx_sh_r[7:1]};
         end else begin
            rx_sh_r <= {rx_sh_r[6:0], in_bit};
         end
      end
   end

   // Receive buffer; a byte not read before the next completes is overwritten.
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_buf_r <= 8'h00;
      end else if (byte_done) begin
         rx_buf_r <= lsb_first_select ? {in_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], in_bit};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dma_req_r <= 1'b0;
      end else begin
         dma_req_r <= byte_done && !is_master;
      end
   end

   // Status-read arming for the read-status-then-access-data clear sequence.
   always_ff @(posedge clk) begin
      if (reset) begin
         done_arm_r <= 1'b0;
         wcol_arm_r <= 1'b0;
      end else begin
         if (sts_rd && xfer_done_flag_r) begin
            done_arm_r <= 1'b1;
         end else if (data_acc) begin
            done_arm_r <= 1'b0;
         end
         if (sts_rd && write_collision_flag_r) begin
            wcol_arm_r <= 1'b1;
         end else if (data_acc) begin
            wcol_arm_r <= 1'b0;
         end
      end
   end

   // Flags: a hardware set in the clearing cycle wins.
   always_ff @(posedge clk) begin
      if (reset) begin
         xfer_done_flag_r <= 1'b0;
      end else if (xfer_done || mode_fault) begin
         xfer_done_flag_r <= 1'b1;
      end else if (irq_ack || (done_arm_r && data_acc)) begin
         xfer_done_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         write_collision_flag_r <= 1'b0;
      end else if (data_wr && enable && busy) begin
         write_collision_flag_r <= 1'b1;
      end else if (wcol_arm_r && data_acc) begin
         write_collision_flag_r <= 1'b0;
      end
   end

   // Read data, valid in the cycle after the strobe only.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_SPI_CONTROL:      reg_rdata <= ctrl_r;
            OFS_IRQ_LEVEL_CONFIG: reg_rdata <= {6'h00, irq_lvl_r};
            OFS_TRANSFER_STATUS:  reg_rdata <= {xfer_done_flag_r, write_collision_flag_r, 6'h00};
            OFS_SHIFT_DATA:       reg_rdata <= rx_buf_r;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign irq_req            = xfer_done_flag_r && (irq_lvl_r != 2'h0);
   assign irq_priority_level = irq_lvl_r;
   assign irq_vector_offset  = IRQ_VECTOR_OFFSET;
   assign dma_req            = dma_req_r;

   // Pin drive: the master owns SCK and MOSI, a selected slave owns MISO.
   assign sck_out  = sck_r;
   assign sck_oe   = enable && is_master;
   assign mosi_out = tx_bit;
   assign mosi_oe  = enable && is_master;
   assign miso_out = tx_bit;
   assign miso_oe  = enable && !is_master && !ss_s;
endmodule
